// file: lmp_addr_match.sv
`timescale 1ns/100ps
module lmp_addr_match (
  input  wire logic [7:0] addr_byte,
  input  wire logic [6:0] node_addr,
  output wire logic       match
);
  wire logic broadcast_all;
  wire logic own_addr;
  // Broadcast bit low addresses every node
  assign broadcast_all = ~addr_byte[lmp_pkg::BROAD_BIT];
  assign own_addr      = (addr_byte[6:0] == node_addr);
  assign match         = broadcast_all | own_addr;
endmodule : lmp_addr_match

// file: lmp_cmd_chk.sv
`timescale 1ns/100ps
module lmp_cmd_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic        frame_end,
  input wire logic        checksum_ok,
  input wire logic        parity_ok,
  input wire logic        position_allowed,
  input wire logic        param_we,
  input wire logic        otp_we,
  input wire logic        pos_go,
  input wire logic        pos_ignored,
  input wire logic        frame_discard,
  input wire logic [1:0]  last_cmd,
  input wire logic [15:0] pos_target,
  input wire logic [7:0]  otp_data,
  input wire logic [3:0]  run_current,
  input wire logic [3:0]  max_velocity
);
  logic good_end;
  assign good_end = ce && frame_end && checksum_ok && parity_ok;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_PARAM_SRC: assert property (param_we |-> $past(good_end, 2))
    else $error("parameter strobe without good frame");
  AST_OTP_SRC: assert property (otp_we |-> $past(good_end, 2))
    else $error("otp strobe without good frame");
  AST_POS_SRC: assert property (pos_go |-> $past(good_end, 2)
    && $past(position_allowed)) else $error("move without permission");
  AST_IGN_CAUSE: assert property (
    pos_ignored |-> $past(good_end, 2) && !$past(position_allowed))
    else $error("ignore flag without cause");
  AST_BAD_FRAME: assert property (ce && frame_end && !good_end
    |-> ##2 !(param_we || otp_we || pos_go)) else $error("bad frame acted on");
  AST_ONE_KIND: assert property (
    $onehot0({param_we, otp_we, pos_go, pos_ignored, frame_discard}))
    else $error("two strobes at once");
  AST_LAST_PAR: assert property (
    param_we |-> last_cmd == lmp_pkg::LAST_PARAM)
    else $error("last kind not parameter");
  AST_LAST_POS: assert property (
    pos_go |-> last_cmd == lmp_pkg::LAST_POS)
    else $error("last kind not position");
  AST_TGT_HOLD: assert property (!pos_go |-> $stable(pos_target))
    else $error("target moved without move strobe");
  AST_PAR_HOLD: assert property (!param_we
    |-> $stable({run_current, max_velocity})) else $error("fields moved");
  AST_OTP_HOLD: assert property (!otp_we |-> $stable(otp_data))
    else $error("otp data moved without strobe");
  AST_STROBE_ONE: assert property (param_we |=> !param_we)
    else $error("parameter strobe too long");
endmodule : lmp_cmd_chk

bind lmp_cmd_decoder lmp_cmd_chk chk_i (
  .clk, .reset, .ce, .frame_end, .checksum_ok, .parity_ok,
  .position_allowed, .param_we, .otp_we, .pos_go, .pos_ignored,
  .frame_discard, .last_cmd, .pos_target, .otp_data, .run_current,
  .max_velocity
);

// file: lmp_cmd_decoder.sv
// Command decoder: parameter, OTP and position frames to strobes and fields.
`timescale 1ns/100ps
module lmp_cmd_decoder (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        frame_start,
  input  wire logic [7:0]  rx_id,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        frame_end,
  input  wire logic        checksum_ok,
  input  wire logic        parity_ok,
  input  wire logic [6:0]  node_addr,
  input  wire logic [5:0]  direct_id,
  input  wire logic [3:0]  gp4_id,
  input  wire logic        position_allowed,
  output logic             param_we,
  output logic [3:0]       run_current,
  output logic [3:0]       hold_current,
  output logic [3:0]       max_velocity,
  output logic [3:0]       min_velocity,
  output logic [10:0]      secure_position,
  output logic             rotation_dir,
  output logic [3:0]       accel_index,
  output logic             acceleration_shape,
  output logic [1:0]       step_resolution,
  output logic             otp_we,
  output logic [2:0]       otp_byte_index,
  output logic [7:0]       otp_data,
  output logic             pos_go,
  output logic [15:0]      pos_target,
  output logic             pos_ignored,
  output logic             frame_discard,
  output logic [1:0]       last_cmd
);

  function automatic logic is_cmd(input logic [7:0] b,
                                  input logic [6:0] code);
    is_cmd = b[lmp_pkg::CMD_FLAG_BIT] && (b[6:0] == code);
  endfunction : is_cmd

  lmp_frame_if frm ();

  lmp_frame_collect u_collect (
    .clk           (clk),
    .reset         (reset),
    .ce            (ce),
    .frame_start   (frame_start),
    .rx_id         (rx_id),
    .rx_byte_valid (rx_byte_valid),
    .rx_byte       (rx_byte),
    .frm           (frm)
  );

  lmp_pkg::lmp_state_t state_r;
  lmp_pkg::lmp_state_t state_nxt;

  logic        frame_ok_r;
  logic        param_we_r;
  logic [3:0]  run_current_r;
  logic [3:0]  hold_current_r;
  logic [3:0]  max_velocity_r;
  logic [3:0]  min_velocity_r;
  logic [10:0] secure_position_r;
  logic        rotation_dir_r;
  logic [3:0]  accel_index_r;
  logic        acceleration_shape_r;
  logic [1:0]  step_resolution_r;
  logic        otp_we_r;
  logic [2:0]  otp_byte_index_r;
  logic [7:0]  otp_data_r;
  logic        pos_go_r;
  logic [15:0] pos_target_r;
  logic        pos_ignored_r;
  logic        frame_discard_r;
  logic [1:0]  last_cmd_r;

  wire logic [7:0] b0;
  wire logic [7:0] b1;
  wire logic [7:0] b2;
  wire logic [7:0] b3;
  wire logic [7:0] b4;
  wire logic [7:0] b5;
  wire logic [7:0] b6;
  wire logic [7:0] b7;
  assign b0 = frm.data[0];
  assign b1 = frm.data[1];
  assign b2 = frm.data[2];
  assign b3 = frm.data[3];
  assign b4 = frm.data[4];
  assign b5 = frm.data[5];
  assign b6 = frm.data[6];
  assign b7 = frm.data[7];

  wire logic deciding;
  wire logic clean_frame;
  assign deciding    = (state_r == lmp_pkg::LMP_DECIDE);
  // Only frames with good checksum, good parity and no overrun count
  assign clean_frame = frame_ok_r && !frm.overflow;

  wire logic is_type4;
  wire logic is_direct;
  wire logic is_gp4;
  assign is_type4  = (frm.id == lmp_pkg::TYPE4_ID) &&
                     (frm.count == lmp_pkg::LEN_TYPE4) &&
                     (b0 == lmp_pkg::APP_CMD_BYTE);
  // Identifier parity bits are checked upstream, only the low six compare
  assign is_direct = (frm.id[5:0] == direct_id) &&
                     (frm.count == lmp_pkg::LEN_DIRECT);
  assign is_gp4    = (frm.id[5:0] == {lmp_pkg::GP4_ID_HIGH, gp4_id}) &&
                     (frm.count == lmp_pkg::LEN_GP4);

  wire logic type4_addr_ok;
  wire logic gp4_addr_ok;
  lmp_addr_match u_match_t4 (
    .addr_byte (b2),
    .node_addr (node_addr),
    .match     (type4_addr_ok)
  );
  lmp_addr_match u_match_gp4 (
    .addr_byte (b1),
    .node_addr (node_addr),
    .match     (gp4_addr_ok)
  );

  wire logic param_hit;
  wire logic otp_fmt_ok;
  wire logic otp_hit;
  wire logic gp4_pos_hit;
  wire logic pos_hit;
  wire logic pos_accept;
  wire logic pos_refuse;
  assign param_hit  = is_type4 && is_cmd(b1, lmp_pkg::CMD_MOTOR_PAR) &&
                      type4_addr_ok;
  assign otp_fmt_ok = (b3[7:3] == lmp_pkg::OTP_IDX_ONES) &&
                      (b5 == lmp_pkg::OTP_FILL_BYTE) &&
                      (b6 == lmp_pkg::OTP_FILL_BYTE) &&
                      (b7 == lmp_pkg::OTP_FILL_BYTE);
  assign otp_hit    = is_type4 && is_cmd(b1, lmp_pkg::CMD_OTP_PROG) &&
                      otp_fmt_ok && type4_addr_ok;
  assign gp4_pos_hit = is_gp4 && is_cmd(b0, lmp_pkg::CMD_POSITION) &&
                       gp4_addr_ok;
  assign pos_hit    = is_direct || gp4_pos_hit;
  assign pos_accept = pos_hit && position_allowed;
  assign pos_refuse = pos_hit && !position_allowed;

  wire logic [15:0] pos_value;
  // Direct frame: high byte first; four-byte frame: after the address
  assign pos_value = is_direct ? {b0, b1} : {b2, b3};

  wire logic [3:0]  run_current_nxt;
  wire logic [3:0]  hold_current_nxt;
  wire logic [3:0]  max_velocity_nxt;
  wire logic [3:0]  min_velocity_nxt;
  wire logic [10:0] secure_position_nxt;
  wire logic        rotation_dir_nxt;
  wire logic [3:0]  accel_index_nxt;
  wire logic        acceleration_shape_nxt;
  wire logic [1:0]  step_resolution_nxt;
  wire logic [2:0]  otp_byte_index_nxt;
  wire logic [7:0]  otp_data_nxt;
  // Parameter fields: currents, speeds, then position, direction, ramp
  assign run_current_nxt        = b3[7:4];
  assign hold_current_nxt       = b3[3:0];
  assign max_velocity_nxt       = b4[7:4];
  assign min_velocity_nxt       = b4[3:0];
  assign secure_position_nxt    = {b5[7:5], b6};
  assign rotation_dir_nxt       = b5[4];
  assign accel_index_nxt        = b5[3:0];
  assign acceleration_shape_nxt = b7[4];
  assign step_resolution_nxt    = b7[3:2];
  // OTP fields: index below the five ones, value in the next byte
  assign otp_byte_index_nxt     = b3[2:0];
  assign otp_data_nxt           = b4;

  wire logic do_param;
  wire logic do_otp;
  wire logic do_pos;
  wire logic do_refuse;
  wire logic do_discard;
  assign do_param   = deciding && clean_frame && param_hit;
  assign do_otp     = deciding && clean_frame && otp_hit;
  assign do_pos     = deciding && clean_frame && pos_accept;
  assign do_refuse  = deciding && clean_frame && pos_refuse;
  assign do_discard = deciding && !clean_frame;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lmp_pkg::LMP_IDLE: begin
        if (frame_start) begin
          state_nxt = lmp_pkg::LMP_RECV;
        end
      end
      lmp_pkg::LMP_RECV: begin
        if (frame_start) begin
          state_nxt = lmp_pkg::LMP_RECV;
        end else if (frame_end) begin
          state_nxt = lmp_pkg::LMP_DECIDE;
        end
      end
      lmp_pkg::LMP_DECIDE: begin
        state_nxt = frame_start ? lmp_pkg::LMP_RECV : lmp_pkg::LMP_IDLE;
      end
      default: begin
        state_nxt = lmp_pkg::LMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= lmp_pkg::LMP_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_ok_r <= 1'b0;
    end else if (ce && state_r == lmp_pkg::LMP_RECV && frame_end) begin
      frame_ok_r <= checksum_ok && parity_ok;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param_we_r <= 1'b0;
    end else if (ce) begin
      param_we_r <= do_param;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      otp_we_r <= 1'b0;
    end else if (ce) begin
      otp_we_r <= do_otp;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_go_r <= 1'b0;
    end else if (ce) begin
      pos_go_r <= do_pos;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_ignored_r <= 1'b0;
    end else if (ce) begin
      pos_ignored_r <= do_refuse;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_discard_r <= 1'b0;
    end else if (ce) begin
      frame_discard_r <= do_discard;
    end
  end

  // No wait on motion: fields take effect on the running move at once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_current_r        <= lmp_pkg::RUN_CUR_RST;
      hold_current_r       <= lmp_pkg::HOLD_CUR_RST;
      max_velocity_r       <= lmp_pkg::VMAX_RST;
      min_velocity_r       <= lmp_pkg::VMIN_RST;
      secure_position_r    <= lmp_pkg::SEC_POS_RST;
      rotation_dir_r       <= 1'b0;
      accel_index_r        <= lmp_pkg::ACC_RST;
      acceleration_shape_r <= 1'b0;
      step_resolution_r    <= lmp_pkg::STEP_RES_RST;
    end else if (ce && do_param) begin
      run_current_r        <= run_current_nxt;
      hold_current_r       <= hold_current_nxt;
      max_velocity_r       <= max_velocity_nxt;
      min_velocity_r       <= min_velocity_nxt;
      secure_position_r    <= secure_position_nxt;
      rotation_dir_r       <= rotation_dir_nxt;
      accel_index_r        <= accel_index_nxt;
      acceleration_shape_r <= acceleration_shape_nxt;
      step_resolution_r    <= step_resolution_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      otp_byte_index_r <= 3'h0;
      otp_data_r       <= 8'h00;
    end else if (ce && do_otp) begin
      otp_byte_index_r <= otp_byte_index_nxt;
      otp_data_r       <= otp_data_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_target_r <= lmp_pkg::TARGET_RST;
    end else if (ce && do_pos) begin
      pos_target_r <= pos_value;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_cmd_r <= lmp_pkg::LAST_NONE;
    end else if (ce) begin
      if (do_param) begin
        last_cmd_r <= lmp_pkg::LAST_PARAM;
      end else if (do_otp) begin
        last_cmd_r <= lmp_pkg::LAST_OTP;
      end else if (do_pos) begin
        last_cmd_r <= lmp_pkg::LAST_POS;
      end
    end
  end

  assign param_we           = param_we_r;
  assign run_current        = run_current_r;
  assign hold_current       = hold_current_r;
  assign max_velocity       = max_velocity_r;
  assign min_velocity       = min_velocity_r;
  assign secure_position    = secure_position_r;
  assign rotation_dir       = rotation_dir_r;
  assign accel_index        = accel_index_r;
  assign acceleration_shape = acceleration_shape_r;
  assign step_resolution    = step_resolution_r;
  assign otp_we             = otp_we_r;
  assign otp_byte_index     = otp_byte_index_r;
  assign otp_data           = otp_data_r;
  assign pos_go             = pos_go_r;
  assign pos_target         = pos_target_r;
  assign pos_ignored        = pos_ignored_r;
  assign frame_discard      = frame_discard_r;
  assign last_cmd           = last_cmd_r;

endmodule : lmp_cmd_decoder

// file: lmp_cmd_decoder_tb.sv
`timescale 1ns/100ps
module lmp_cmd_decoder_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        position_allowed = 1'b1;
  logic        ce = 1'b1;
  logic        frame_start, rx_byte_valid, frame_end, checksum_ok, parity_ok;
  logic [7:0]  rx_id, rx_byte, otp_data;
  logic        param_we, otp_we, pos_go, pos_ignored, frame_discard;
  logic        rotation_dir, acceleration_shape;
  logic [3:0]  run_current, hold_current, max_velocity, min_velocity;
  logic [3:0]  accel_index;
  logic [10:0] secure_position;
  logic [1:0]  step_resolution, last_cmd;
  logic [2:0]  otp_byte_index;
  logic [15:0] pos_target;
  wire  [18:0] misc = {secure_position, rotation_dir, accel_index,
                       acceleration_shape, step_resolution};
  wire  [15:0] speeds = {run_current, hold_current, max_velocity,
                         min_velocity};
  int          n_fail = 0;
  int          n_tests = 0;

  always #50 clk = ~clk;

  lmp_lin_master master (.clk, .frame_start, .rx_id, .rx_byte_valid,
    .rx_byte, .frame_end, .checksum_ok, .parity_ok);

  // Node 0x15; distinct direct and four-byte identifiers
  lmp_cmd_decoder uut (.clk, .reset, .ce, .frame_start, .rx_id,
    .rx_byte_valid, .rx_byte, .frame_end, .checksum_ok, .parity_ok,
    .node_addr(7'h15), .direct_id(6'h0a), .gp4_id(4'h3), .position_allowed,
    .param_we, .run_current, .hold_current, .max_velocity, .min_velocity,
    .secure_position, .rotation_dir, .accel_index, .acceleration_shape,
    .step_resolution, .otp_we, .otp_byte_index, .otp_data, .pos_go,
    .pos_target, .pos_ignored, .frame_discard, .last_cmd);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Strobes in order: param, otp, move, ignored, discard
  task automatic run(input logic [7:0] id, input logic [63:0] pl,
                     input int n, input logic ok, input logic [4:0] st);
    master.send(id, pl, n, ok);
    @(posedge clk);
    #1;
    chk({param_we, otp_we, pos_go, pos_ignored, frame_discard}, st);
  endtask : run

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({last_cmd, param_we, otp_we, pos_go, pos_target}, 0);
    run(8'h3c, 64'h8089_955a_c3b6_7e18, 8, 1'b1, 5'b10000);
    chk(speeds, 16'h5ac3);
    chk(misc, {11'h57e, 1'b1, 4'h6, 1'b1, 2'h2});
    chk(last_cmd, lmp_pkg::LAST_PARAM);
    // The second parameter frame changes the top speed and uses a broadcast address byte
    run(8'h3c, 64'h8089_225a_93b6_7e18, 8, 1'b1, 5'b10000);
    chk(max_velocity, 4'h9);
    run(8'h3c, 64'h8089_a25a_13b6_7e18, 8, 1'b1, 5'b00000);
    run(8'h3c, 64'h8089_955a_13b6_7e18, 8, 1'b0, 5'b00001);
    run(8'h3c, 64'h8089_955a_13b6_7e18, 7, 1'b1, 5'b00000);
    run(8'h3c, 64'h8089_955a_13b6_7e18, 9, 1'b1, 5'b00001);
    chk(max_velocity, 4'h9);
    run(8'h3c, 64'h8090_22fd_a7ff_ffff, 8, 1'b1, 5'b01000);
    chk({otp_byte_index, otp_data}, 11'h5a7);
    chk(last_cmd, lmp_pkg::LAST_OTP);
    run(8'h3c, 64'h8090_95fd_3cfe_ffff, 8, 1'b1, 5'b00000);
    chk(otp_data, 8'ha7);
    run(8'h8a, 64'h1234_0000_0000_0000, 2, 1'b1, 5'b00100);
    chk(pos_target, 16'h1234);
    run(8'h23, 64'h8b22_abcd_0000_0000, 4, 1'b1, 5'b00100);
    chk({pos_target, last_cmd}, {16'habcd, 2'h3});
    @(posedge clk);
    position_allowed <= 1'b0;
    run(8'h23, 64'h8b95_0001_0000_0000, 4, 1'b1, 5'b00010);
    chk(pos_target, 16'habcd);
    @(posedge clk);
    ce <= 1'b0;
    run(8'h3c, 64'h8089_225a_73b6_7e18, 8, 1'b1, 5'b00000);
    chk({max_velocity, last_cmd}, {4'h9, 2'h3});
    complete_run();
  end
endmodule : lmp_cmd_decoder_tb

// file: lmp_frame_collect.sv
`timescale 1ns/100ps
module lmp_frame_collect (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       frame_start,
  input  wire logic [7:0] rx_id,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  lmp_frame_if.collector  frm
);
  wire logic room;
  assign room = (frm.count < 4'(lmp_pkg::MAX_BYTES));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frm.id       <= 8'h00;
      frm.count    <= 4'h0;
      frm.overflow <= 1'b0;
    end else if (ce && frame_start) begin
      frm.id       <= rx_id;
      frm.count    <= 4'h0;
      frm.overflow <= 1'b0;
    end else if (ce && rx_byte_valid) begin
      if (room) begin
        frm.count <= frm.count + 4'h1;
      end else begin
        frm.overflow <= 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < lmp_pkg::MAX_BYTES; gi++) begin : g_byte
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          frm.data[gi] <= 8'h00;
        end else if (ce && !frame_start && rx_byte_valid && room &&
                     frm.count == 4'(gi)) begin
          frm.data[gi] <= rx_byte;
        end
      end
    end
  endgenerate
endmodule : lmp_frame_collect

// file: lmp_frame_if.sv
`timescale 1ns/100ps
interface lmp_frame_if;
  logic [7:0] id;
  logic [7:0] data [lmp_pkg::MAX_BYTES];
  logic [3:0] count;
  logic       overflow;

  modport collector (
    output id,
    output data,
    output count,
    output overflow
  );
  modport consumer (
    input  id,
    input  data,
    input  count,
    input  overflow
  );
endinterface : lmp_frame_if

// file: lmp_lin_master.sv
`timescale 1ns/100ps
module lmp_lin_master (
  input  wire logic       clk,
  output logic            frame_start,
  output logic [7:0]      rx_id,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            frame_end,
  output logic            checksum_ok,
  output logic            parity_ok
);
  initial begin
    frame_start = 1'b0;
    rx_id = 8'h00;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    frame_end = 1'b0;
    checksum_ok = 1'b0;
    parity_ok = 1'b0;
  end

  // Identifier, then n bytes from the top of pl, then the frame end
  task automatic send(input logic [7:0] id, input logic [63:0] pl,
                      input int n, input logic ok);
    @(posedge clk);
    frame_start <= 1'b1;
    rx_id <= id;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      frame_start <= 1'b0;
      rx_id <= ~id;
      rx_byte_valid <= 1'b1;
      rx_byte <= pl[63-8*(i%8) -: 8];
    end
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    frame_end <= 1'b1;
    checksum_ok <= ok;
    parity_ok <= ok;
    @(posedge clk);
    frame_end <= 1'b0;
    checksum_ok <= ~ok;
    parity_ok <= ~ok;
  endtask : send
endmodule : lmp_lin_master

// file: lmp_pkg.sv
package lmp_pkg;
  localparam logic [7:0] TYPE4_ID      = 8'h3c;
  localparam logic [7:0] APP_CMD_BYTE  = 8'h80;
  localparam logic [6:0] CMD_MOTOR_PAR = 7'h09;
  localparam logic [6:0] CMD_OTP_PROG  = 7'h10;
  localparam logic [6:0] CMD_POSITION  = 7'h0b;
  localparam logic [7:0] OTP_FILL_BYTE = 8'hff;
  localparam logic [4:0] OTP_IDX_ONES  = 5'h1f;
  localparam logic [1:0] GP4_ID_HIGH   = 2'h2;
  localparam int         MAX_BYTES     = 8;
  localparam logic [3:0] LEN_TYPE4     = 4'h8;
  localparam logic [3:0] LEN_DIRECT    = 4'h2;
  localparam logic [3:0] LEN_GP4       = 4'h4;
  localparam int         CMD_FLAG_BIT  = 7;
  localparam int         BROAD_BIT     = 7;
  localparam logic [3:0] RUN_CUR_RST   = 4'h0;
  localparam logic [3:0] HOLD_CUR_RST  = 4'h0;
  localparam logic [3:0] VMAX_RST      = 4'h0;
  localparam logic [3:0] VMIN_RST      = 4'h0;
  localparam logic [10:0] SEC_POS_RST  = 11'h000;
  localparam logic [3:0] ACC_RST       = 4'h0;
  localparam logic [1:0] STEP_RES_RST  = 2'h0;
  localparam logic [15:0] TARGET_RST   = 16'h0000;
  localparam logic [1:0] LAST_NONE     = 2'h0;
  localparam logic [1:0] LAST_PARAM    = 2'h1;
  localparam logic [1:0] LAST_OTP      = 2'h2;
  localparam logic [1:0] LAST_POS      = 2'h3;

  typedef enum logic [1:0] {
    LMP_IDLE   = 2'b00,
    LMP_RECV   = 2'b01,
    LMP_DECIDE = 2'b10
  } lmp_state_t;
endpackage : lmp_pkg
